// file: src/lcp_parser.sv
`timescale 1ns/100ps
module lcp_parser #(
  parameter logic [lcp_pkg::NPARAM*16-1:0] SEL_LIST = 64'h5030_5031_5032_5033
) (
  input  wire logic                                   clk,
  input  wire logic                                   nrst,
  input  wire logic                                   ce,
  input  wire logic                                   rx_valid,
  input  wire logic [7:0]                             rx_byte,
  output logic                                        resp_valid,
  output lcp_pkg::lcp_resp_s                          resp,
  output logic [lcp_pkg::NPARAM-1:0][lcp_pkg::VAL_W-1:0] cfg_active,
  output logic [lcp_pkg::NPARAM-1:0]                  cfg_pending
);
  import lcp_pkg::*;

  // ****************************************************************
  // Selector lookup
  // ****************************************************************
  function automatic logic [IDX_W:0] find_sel(input logic [15:0] sel);
    logic [IDX_W:0] res;
    res = '0;
    for (int i = 0; i < NPARAM; i++) begin
      if (SEL_LIST[(NPARAM-1-i)*16 +: 16] == sel) begin
        res = {1'b1, IDX_W'(i)};
      end
    end
    return res;
  endfunction : find_sel

  // ****************************************************************
  // State
  // ****************************************************************
  lcp_state_e                   st_r,     st_nxt;
  logic [15:0]                  len_r,    len_nxt;
  logic [15:0]                  rem_r,    rem_nxt;
  logic [7:0]                   sum_r,    sum_nxt;
  logic [7:0]                   ftype_r,  ftype_nxt;
  logic [7:0]                   fid_r,    fid_nxt;
  logic [15:0]                  cmd_r,    cmd_nxt;
  logic [VAL_W-1:0]             val_r,    val_nxt;
  logic [NPARAM-1:0][VAL_W-1:0] act_r,    act_nxt;
  logic [NPARAM-1:0][VAL_W-1:0] pend_r,   pend_nxt;
  logic [NPARAM-1:0]            pv_r,     pv_nxt;
  logic                         rv_r,     rv_nxt;
  lcp_resp_s                    resp_r,   resp_nxt;

  logic                         take;
  logic                         chk_fire;
  logic                         sum_ok;
  logic                         len_ok;
  logic                         type_ok;
  logic                         frame_ok;
  logic                         has_val;
  logic                         is_apply;
  logic                         commit;
  logic [IDX_W:0]               hit_idx;
  logic                         hit;
  logic [IDX_W-1:0]             idx;
  logic [7:0]                   sum_add;
  logic [15:0]                  rem_dec;

  assign take     = ce && rx_valid;
  assign chk_fire = take && (st_r == LCP_CHK);
  assign sum_add  = sum_r + rx_byte;
  assign rem_dec  = rem_r - 16'h0001;
  assign sum_ok   = (sum_add == CHK_GOOD);
  assign len_ok   = (len_r >= HDR_BYTES) && (len_r - HDR_BYTES <= 16'(VAL_BYTES));
  assign type_ok  = (ftype_r == TYPE_IMM) || (ftype_r == TYPE_QUEUE);
  assign frame_ok = sum_ok && len_ok && type_ok;
  assign has_val  = (len_r > HDR_BYTES);
  assign is_apply = (cmd_r == APPLY_SEL);
  assign hit_idx  = find_sel(cmd_r);
  assign hit      = hit_idx[IDX_W];
  assign idx      = hit_idx[IDX_W-1:0];
  assign commit   = (ftype_r == TYPE_IMM) || is_apply;

  // ****************************************************************
  // Byte framing
  // ****************************************************************
  always_comb begin
    st_nxt    = st_r;
    len_nxt   = len_r;
    rem_nxt   = rem_r;
    sum_nxt   = sum_r;
    ftype_nxt = ftype_r;
    fid_nxt   = fid_r;
    cmd_nxt   = cmd_r;
    val_nxt   = val_r;
    if (take) begin
      case (st_r)
        LCP_HUNT: begin
          // Anything other than the delimiter is dropped here.
          if (rx_byte == START_DELIM) begin
            st_nxt  = LCP_LEN_H;
            sum_nxt = '0;
            val_nxt = '0;
            ftype_nxt = '0;
            fid_nxt = '0;
            cmd_nxt = '0;
          end
        end
        LCP_LEN_H: begin
          len_nxt = {rx_byte, len_r[7:0]};
          st_nxt  = LCP_LEN_L;
        end
        LCP_LEN_L: begin
          len_nxt = {len_r[15:8], rx_byte};
          rem_nxt = {len_r[15:8], rx_byte};
          st_nxt  = ({len_r[15:8], rx_byte} == 16'h0000) ? LCP_CHK : LCP_TYPE;
        end
        LCP_CHK: begin
          st_nxt = LCP_HUNT;
        end
        default: begin
          sum_nxt = sum_add;
          rem_nxt = rem_dec;
          case (st_r)
            LCP_TYPE: begin
              ftype_nxt = rx_byte;
              st_nxt    = LCP_FID;
            end
            LCP_FID: begin
              fid_nxt = rx_byte;
              st_nxt  = LCP_CMD0;
            end
            LCP_CMD0: begin
              cmd_nxt = {rx_byte, cmd_r[7:0]};
              st_nxt  = LCP_CMD1;
            end
            LCP_CMD1: begin
              cmd_nxt = {cmd_r[15:8], rx_byte};
              st_nxt  = LCP_VAL;
            end
            LCP_VAL: begin
              val_nxt = {val_r[VAL_W-9:0], rx_byte};
            end
            default: begin
              st_nxt = LCP_HUNT;
            end
          endcase
          if (rem_dec == 16'h0000) begin
            st_nxt = LCP_CHK;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Parameter store and reply
  // ****************************************************************
  always_comb begin
    act_nxt  = act_r;
    pend_nxt = pend_r;
    pv_nxt   = pv_r;
    rv_nxt   = 1'b0;
    resp_nxt = resp_r;
    if (chk_fire) begin
      if (frame_ok) begin
        if (commit) begin
          for (int i = 0; i < NPARAM; i++) begin
            if (pv_r[i]) begin
              act_nxt[i] = pend_r[i];
            end
          end
          pv_nxt = '0;
        end
        if (has_val && hit) begin
          if (ftype_r == TYPE_IMM) begin
            act_nxt[idx] = val_r;
          end else if (!is_apply) begin
            pend_nxt[idx] = val_r;
            pv_nxt[idx]   = 1'b1;
          end
        end
        rv_nxt          = (fid_r != 8'h00);
        resp_nxt.ftype  = TYPE_RESP;
        resp_nxt.fid    = fid_r;
        resp_nxt.cmd    = cmd_r;
        resp_nxt.status = (hit || is_apply) ? ST_OK : ST_BAD_CMD;
        resp_nxt.value  = (!has_val && hit) ? act_nxt[idx] : '0;
      end else begin
        rv_nxt          = 1'b1;
        resp_nxt.ftype  = TYPE_STATUS;
        resp_nxt.fid    = fid_r;
        resp_nxt.cmd    = cmd_r;
        resp_nxt.value  = '0;
        resp_nxt.status = !sum_ok ? ST_BAD_CHK : (!len_ok ? ST_BAD_LEN : ST_BAD_TYPE);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r    <= LCP_HUNT;
      len_r   <= '0;
      rem_r   <= '0;
      sum_r   <= '0;
      ftype_r <= '0;
      fid_r   <= '0;
      cmd_r   <= '0;
      val_r   <= '0;
      act_r   <= {NPARAM{VAL_RST}};
      pend_r  <= {NPARAM{VAL_RST}};
      pv_r    <= '0;
      rv_r    <= 1'b0;
      resp_r  <= '0;
    end else if (ce) begin
      st_r    <= st_nxt;
      len_r   <= len_nxt;
      rem_r   <= rem_nxt;
      sum_r   <= sum_nxt;
      ftype_r <= ftype_nxt;
      fid_r   <= fid_nxt;
      cmd_r   <= cmd_nxt;
      val_r   <= val_nxt;
      act_r   <= act_nxt;
      pend_r  <= pend_nxt;
      pv_r    <= pv_nxt;
      rv_r    <= rv_nxt;
      resp_r  <= resp_nxt;
    end
  end

  assign resp_valid  = rv_r;
  assign resp        = resp_r;
  assign cfg_active  = act_r;
  assign cfg_pending = pv_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_imm_write;
    @(posedge clk) disable iff (!nrst)
      (chk_fire && frame_ok && ftype_r == TYPE_IMM && has_val && hit)
      |=> (act_r[$past(idx)] == $past(val_r)) && (pv_r == '0);
  endproperty
  a_imm_write: assert property (p_imm_write) else $error("immediate write not applied");

  property p_queue_hold;
    @(posedge clk) disable iff (!nrst)
      (chk_fire && frame_ok && ftype_r == TYPE_QUEUE && has_val && hit && !is_apply)
      |=> (act_r == $past(act_r)) && (pend_r[$past(idx)] == $past(val_r)) && pv_r[$past(idx)];
  endproperty
  a_queue_hold: assert property (p_queue_hold) else $error("queued write misplaced");

  property p_apply;
    @(posedge clk) disable iff (!nrst)
      (chk_fire && frame_ok && is_apply && pv_r[NPARAM-1])
      |=> (pv_r == '0) && (act_r[NPARAM-1] == $past(pend_r[NPARAM-1]));
  endproperty
  a_apply: assert property (p_apply) else $error("apply did not commit");

  property p_query;
    @(posedge clk) disable iff (!nrst)
      (chk_fire && frame_ok && !has_val && ftype_r == TYPE_QUEUE && !is_apply)
      |=> (act_r == $past(act_r)) && (pend_r == $past(pend_r)) && (pv_r == $past(pv_r));
  endproperty
  a_query: assert property (p_query) else $error("query changed a parameter");

  property p_fid_echo;
    @(posedge clk) disable iff (!nrst)
      (chk_fire && frame_ok && fid_r != 8'h00)
      |=> resp_valid && (resp.fid == $past(fid_r)) && (resp.ftype == TYPE_RESP);
  endproperty
  a_fid_echo: assert property (p_fid_echo) else $error("reply identifier wrong");

  property p_fid_zero;
    @(posedge clk) disable iff (!nrst)
      (chk_fire && frame_ok && fid_r == 8'h00) |=> !resp_valid;
  endproperty
  a_fid_zero: assert property (p_fid_zero) else $error("reply sent for identifier 0");

  property p_hunt;
    @(posedge clk) disable iff (!nrst)
      (take && st_r == LCP_HUNT && rx_byte != START_DELIM) |=> (st_r == LCP_HUNT) && !resp_valid;
  endproperty
  a_hunt: assert property (p_hunt) else $error("stray byte left hunt");

  property p_bad_chk;
    @(posedge clk) disable iff (!nrst)
      (chk_fire && !sum_ok)
      |=> resp_valid && (resp.ftype == TYPE_STATUS) && (resp.status == ST_BAD_CHK)
          && (act_r == $past(act_r)) && (pend_r == $past(pend_r));
  endproperty
  a_bad_chk: assert property (p_bad_chk) else $error("bad checksum not reported");

  property p_len_count;
    @(posedge clk) disable iff (!nrst)
      (take && st_r == LCP_LEN_L && {len_r[15:8], rx_byte} == 16'h0005)
      |=> (rem_r == 16'h0005) && (st_r == LCP_TYPE);
  endproperty
  a_len_count: assert property (p_len_count) else $error("length not loaded");

  c_set:   cover property (@(posedge clk) disable iff (!nrst)
                           chk_fire && frame_ok && has_val && ftype_r == TYPE_IMM);
  c_queue: cover property (@(posedge clk) disable iff (!nrst)
                           chk_fire && frame_ok && has_val && ftype_r == TYPE_QUEUE);
  c_query: cover property (@(posedge clk) disable iff (!nrst)
                           chk_fire && frame_ok && !has_val && fid_r != 8'h00);
  c_bad:   cover property (@(posedge clk) disable iff (!nrst) chk_fire && !sum_ok);

endmodule : lcp_parser

// file: src/lcp_pkg.sv
package lcp_pkg;

  // ****************************************************************
  // Frame constants
  // ****************************************************************
  localparam logic [7:0]  START_DELIM   = 8'h7e;
  localparam logic [7:0]  TYPE_IMM      = 8'h08;
  localparam logic [7:0]  TYPE_QUEUE    = 8'h09;
  localparam logic [7:0]  TYPE_RESP     = 8'h88;
  localparam logic [7:0]  TYPE_STATUS   = 8'h8a;
  localparam logic [7:0]  CHK_GOOD      = 8'hff;
  localparam logic [15:0] HDR_BYTES     = 16'h0004;
  localparam logic [15:0] APPLY_SEL     = 16'h4143;

  // ****************************************************************
  // Status codes carried in the reply
  // ****************************************************************
  localparam logic [7:0]  ST_OK         = 8'h00;
  localparam logic [7:0]  ST_BAD_CMD    = 8'h02;
  localparam logic [7:0]  ST_BAD_CHK    = 8'h10;
  localparam logic [7:0]  ST_BAD_LEN    = 8'h11;
  localparam logic [7:0]  ST_BAD_TYPE   = 8'h12;

  // ****************************************************************
  // Storage layout and reset values
  // ****************************************************************
  localparam int          VAL_BYTES     = 4;
  localparam int          VAL_W         = 8 * VAL_BYTES;
  localparam logic [VAL_W-1:0] VAL_RST  = 32'h0000_0000;
  localparam int          NPARAM        = 4;
  localparam int          IDX_W         = 2;

  typedef enum logic [3:0] {
    LCP_HUNT  = 4'h0,
    LCP_LEN_H = 4'h1,
    LCP_LEN_L = 4'h2,
    LCP_TYPE  = 4'h3,
    LCP_FID   = 4'h4,
    LCP_CMD0  = 4'h5,
    LCP_CMD1  = 4'h6,
    LCP_VAL   = 4'h7,
    LCP_CHK   = 4'h8
  } lcp_state_e;

  typedef struct packed {
    logic [7:0]       ftype;
    logic [7:0]       fid;
    logic [15:0]      cmd;
    logic [7:0]       status;
    logic [VAL_W-1:0] value;
  } lcp_resp_s;

endpackage : lcp_pkg

// file: tb/lcp_host_model.sv
`timescale 1ns/100ps
module lcp_host_model (
  input  wire logic       clk,
  output logic            ce,
  output logic            rx_valid,
  output logic [7:0]      rx_byte
);
  initial begin
    ce       = 1'b1;
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
  end

  // ****************************************************************
  // Byte level
  // ****************************************************************
  // A slow host shows each byte one cycle with the enable low before it is taken.
  task automatic put(input logic [7:0] b, input bit slow);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_byte  = b;
    ce       = !slow;
    if (slow) begin
      @(negedge clk);
      ce = 1'b1;
    end
  endtask : put

  // A released line never keeps showing the last byte.
  task automatic idle();
    @(negedge clk);
    rx_valid = 1'b0;
    rx_byte  = ~rx_byte;
  endtask : idle

  // ****************************************************************
  // Frame level
  // ****************************************************************
  task automatic frame(input logic [7:0] ft, input logic [7:0] fid, input logic [15:0] cmd,
                       input logic [7:0] v[$], input bit slow, input bit bad_chk);
    logic [7:0]  sum;
    logic [15:0] len;
    len = 16'h0004 + 16'(v.size());
    sum = ft + fid + cmd[15:8] + cmd[7:0];
    foreach (v[i]) sum += v[i];
    put(8'h7e, slow);
    put(len[15:8], slow);
    put(len[7:0], slow);
    put(ft, slow);
    put(fid, slow);
    put(cmd[15:8], slow);
    put(cmd[7:0], slow);
    foreach (v[i]) put(v[i], slow);
    put((8'hff - sum) ^ {7'h00, bad_chk}, slow);
    idle();
  endtask : frame
endmodule : lcp_host_model

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import lcp_pkg::*;
  logic                         clk;
  logic                         nrst;
  logic                         ce;
  logic                         rx_valid;
  logic [7:0]                   rx_byte;
  logic                         resp_valid;
  lcp_resp_s                    resp;
  logic [NPARAM-1:0][VAL_W-1:0] cfg_active;
  logic [NPARAM-1:0]            cfg_pending;
  lcp_resp_s                    rq[$];
  lcp_resp_s                    r;
  logic [7:0]                   nov[$];
  int                           error_cnt;
  int                           n_checks;

  lcp_parser DUT (.clk(clk), .nrst(nrst), .ce(ce), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .resp_valid(resp_valid), .resp(resp), .cfg_active(cfg_active), .cfg_pending(cfg_pending));
  lcp_host_model host (.clk(clk), .ce(ce), .rx_valid(rx_valid), .rx_byte(rx_byte));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (resp_valid === 1'b1) rq.push_back(resp);
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic send(input logic [7:0] ft, input logic [7:0] fid, input logic [15:0] cmd,
                      input logic [7:0] v[$], input bit slow = 0, input bit bad = 0);
    host.frame(ft, fid, cmd, v, slow, bad);
    repeat (3) @(negedge clk);
  endtask : send

  // Checks how many replies came since the last call and keeps the first.
  task automatic get_resp(input int n);
    chk(72'(rq.size()), 72'(n));
    r = (rq.size() != 0) ? rq[0] : '0;
    rq.delete();
  endtask : get_resp

  task automatic test_done();
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_query();
    host.put(8'h00, 0);
    host.put(8'h55, 0);
    host.put(8'h7d, 0);
    host.idle();
    send(TYPE_IMM, 8'h17, 16'h5030, nov);
    get_resp(1);
    chk(r, {TYPE_RESP, 8'h17, 16'h5030, ST_OK, 32'h0});
  endtask : t_query

  task automatic t_imm();
    send(TYPE_IMM, 8'h01, 16'h5031, '{8'h12, 8'h34}, 1);
    get_resp(1);
    chk(r, {TYPE_RESP, 8'h01, 16'h5031, ST_OK, 32'h0});
    chk(72'(cfg_active[1]), 72'h1234);
    send(TYPE_IMM, 8'h00, 16'h5032, '{8'hab});
    get_resp(0);
    chk(72'(cfg_active[2]), 72'hab);
  endtask : t_imm

  task automatic t_queue();
    send(TYPE_QUEUE, 8'h02, 16'h5033, '{8'h11, 8'h22, 8'h33, 8'h44});
    get_resp(1);
    chk(72'(cfg_active[3]), 72'h0);
    chk(72'(cfg_pending[3]), 72'h1);
    send(TYPE_QUEUE, 8'h03, 16'h5033, '{8'h55, 8'h66, 8'h77, 8'h88}, 1);
    get_resp(1);
    send(TYPE_QUEUE, 8'h04, 16'h5033, nov);
    get_resp(1);
    chk(r, {TYPE_RESP, 8'h04, 16'h5033, ST_OK, 32'h0});
    chk(72'(cfg_pending[3]), 72'h1);
    send(TYPE_QUEUE, 8'h05, APPLY_SEL, nov);
    get_resp(1);
    chk(72'(cfg_active[3]), 72'h5566_7788);
    chk(72'(cfg_pending), 72'h0);
  endtask : t_queue

  task automatic t_commit();
    send(TYPE_QUEUE, 8'h06, 16'h5030, '{8'h7e});
    get_resp(1);
    chk(72'(cfg_active[0]), 72'h0);
    send(TYPE_IMM, 8'h07, 16'h5031, nov);
    get_resp(1);
    chk(72'(r.value), 72'h1234);
    chk(72'(cfg_active[0]), 72'h7e);
  endtask : t_commit

  task automatic t_bad();
    send(TYPE_IMM, 8'h08, 16'h5030, '{8'h99}, 0, 1);
    get_resp(1);
    chk(72'({r.ftype, r.status}), 72'({TYPE_STATUS, ST_BAD_CHK}));
    send(8'h10, 8'h09, 16'h5030, nov);
    get_resp(1);
    chk(72'({r.ftype, r.status}), 72'({TYPE_STATUS, ST_BAD_TYPE}));
    send(TYPE_IMM, 8'h0a, 16'h5030, '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05});
    get_resp(1);
    chk(72'({r.ftype, r.status}), 72'({TYPE_STATUS, ST_BAD_LEN}));
    chk(72'(cfg_active[0]), 72'h7e);
    send(TYPE_IMM, 8'h0b, 16'h5a5a, nov);
    get_resp(1);
    chk(72'({r.ftype, r.status}), 72'({TYPE_RESP, ST_BAD_CMD}));
  endtask : t_bad

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    nrst = 1'b0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    t_query();
    t_imm();
    t_queue();
    t_commit();
    t_bad();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule : tb_top
